// *** logic/gp_timer_consts.svh ***
// Register map, field positions and reset values of the timer block.
`ifndef GP_TIMER_CONSTS_SVH
`define GP_TIMER_CONSTS_SVH

`define ADDR_SINGLE_CTL   4'h0
`define ADDR_SINGLE_CNT   4'h1
`define ADDR_SINGLE_PER   4'h2
`define ADDR_LOWER_CTL    4'h3
`define ADDR_UPPER_CTL    4'h4
`define ADDR_LOWER_CNT    4'h5
`define ADDR_UPPER_CNT    4'h6
`define ADDR_LOWER_PER    4'h7
`define ADDR_UPPER_PER    4'h8
`define ADDR_IRQ_FLAGS    4'h9
`define ADDR_IRQ_CFG      4'hA

`define BIT_RUN           15
`define BIT_IDLE_HALT     13
`define BIT_GATE_EN       6
`define BIT_PRESC_HI      5
`define BIT_PRESC_LO      4
`define BIT_PAIR_MODE     3
`define BIT_SYNC_SEL      2
`define BIT_CLK_SRC       1

`define MASK_SINGLE_CTL   16'hA076
`define MASK_LOWER_CTL    16'hA07A
`define MASK_UPPER_CTL    16'hA072
`define MASK_IRQ_CFG      16'h0FFF
`define MASK_IRQ_FLAGS    16'h0007

`define CTL_RESET         16'h0000
`define CNT_RESET         16'h0000
`define PER_RESET         16'hFFFF

`define PRESC_LIM_1       8'h00
`define PRESC_LIM_8       8'h07
`define PRESC_LIM_64      8'h3F
`define PRESC_LIM_256     8'hFF

`endif

// *** logic/gp_timer_pkg.sv ***
// Types shared by the timer block.
package gp_timer_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0]
    {
        PRESC_DIV1   = 2'b00,
        PRESC_DIV8   = 2'b01,
        PRESC_DIV64  = 2'b10,
        PRESC_DIV256 = 2'b11
    } presc_sel_t;
    typedef enum logic [1:0]
    {
        TMR_SINGLE = 2'b00,
        TMR_LOWER  = 2'b01,
        TMR_UPPER  = 2'b10
    } tmr_idx_t;
endpackage

// *** logic/gp_timer.sv ***
// Single 16-bit timer plus a 16/32-bit timer pair with register port.
`timescale 1ns/1ps
`include "gp_timer_consts.svh"

module gp_timer
    import gp_timer_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        clk_en_in,
    // Device power state
    input  wire logic        idle_in,
    // External clock and gate pins
    input  wire logic        single_timer_ext_clock_pin_in,
    input  wire logic        pair_ext_clock_pin_in,
    input  wire logic        upper_ext_clock_pin_in,
    // Register port
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wr_data_in,
    input  wire logic        wr_stb_in,
    input  wire logic        rd_stb_in,
    output logic      [15:0] rd_data_out,
    // Interrupt flags and requests
    output logic      [2:0]  irq_flag_out,
    output logic      [2:0]  irq_req_out,
    output logic      [2:0]  single_timer_irq_priority_out,
    output logic      [2:0]  lower_irq_priority_out,
    output logic      [2:0]  pair_irq_priority_out,
    // Time bases and converter trigger
    output logic      [15:0] pair_count_low_out,
    output logic      [15:0] pair_count_high_out,
    output logic             adc_trigger_out
);

    localparam int NTMR = 3;
    word_t       ctl_q [NTMR];
    word_t       cnt_q [NTMR];
    word_t       per_q [NTMR];
    logic [2:0]  flag_q;
    logic [11:0] irq_cfg_q;
    logic [15:0] rd_data_q;
    logic [2:0]  irq_req_q;
    logic        adc_trig_q;
    logic        pair_mode;
    logic [NTMR-1:0] tick;
    logic [NTMR-1:0] gate_fall;
    logic        wr_ok;
    logic        rd_ok;
    assign wr_ok = wr_stb_in & clk_en_in;
    assign rd_ok = rd_stb_in & clk_en_in;
    assign pair_mode = ctl_q[TMR_LOWER][`BIT_PAIR_MODE];

    // Terminal count of the prescaler for a select code.
    function automatic logic [7:0] presc_limit(input logic [1:0] sel);
        logic [7:0] lim;
        lim = `PRESC_LIM_1;
        unique case (presc_sel_t'(sel))
            PRESC_DIV1:   lim = `PRESC_LIM_1;
            PRESC_DIV8:   lim = `PRESC_LIM_8;
            PRESC_DIV64:  lim = `PRESC_LIM_64;
            PRESC_DIV256: lim = `PRESC_LIM_256;
        endcase
        return lim;
    endfunction

    // Write mask of the control register at a given index.
    function automatic word_t ctl_mask(input int idx);
        word_t m;
        m = `MASK_SINGLE_CTL;
        if (idx == 1)
        begin
            m = `MASK_LOWER_CTL;
        end
        else if (idx == 2)
        begin
            m = `MASK_UPPER_CTL;
        end
        return m;
    endfunction

    logic [NTMR-1:0] pins;
    assign pins = {upper_ext_clock_pin_in, pair_ext_clock_pin_in,
                   single_timer_ext_clock_pin_in};
    // Per timer: pin synchroniser, clock source, gate and prescaler.
    genvar gi;
    generate
        for (gi = 0; gi < NTMR; gi++)
        begin : g_tick
            logic       s1_q;
            logic       s2_q;
            logic       s3_q;
            logic       lvl_q;
            logic       lvl_d1_q;
            logic [7:0] pre_q;
            word_t      ctl;
            logic       ext;
            logic       gated;
            logic       active;
            logic       src_tick;
            logic       raw_rise;
            logic       lvl_rise;

            // The upper timer follows the lower control word when joined.
            assign ctl = (gi == 2 && pair_mode) ? ctl_q[TMR_LOWER] : ctl_q[gi];
            assign ext = ctl[`BIT_CLK_SRC];
            assign gated = ctl[`BIT_GATE_EN] & ~ext;
            assign active = ctl[`BIT_RUN] & ~(idle_in & ctl[`BIT_IDLE_HALT]);
            assign raw_rise = s2_q & ~s3_q;
            assign lvl_rise = lvl_q & ~lvl_d1_q;

            // Unsynchronised counting skips the agreement filter, saving two cycles
            // of latency; only the single timer offers it.
            always_comb
            begin
                if (!ext)
                begin
                    src_tick = ~gated | lvl_q;
                end
                else if (gi == 0 && !ctl[`BIT_SYNC_SEL])
                begin
                    src_tick = raw_rise;
                end
                else
                begin
                    src_tick = lvl_rise;
                end
            end

            always_ff @(posedge clk_in)
            begin
                if (!rst_b_in)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end
                else if (clk_en_in)
                begin
                    s1_q <= pins[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            always_ff @(posedge clk_in)
            begin
                if (!rst_b_in)
                begin
                    lvl_q    <= 1'b0;
                    lvl_d1_q <= 1'b0;
                end
                else if (clk_en_in)
                begin
                    if (s2_q == s3_q)
                    begin
                        lvl_q <= s3_q;
                    end
                    lvl_d1_q <= lvl_q;
                end
            end

            // The prescaler restarts whenever the run bit is clear; an idle halt only holds it.
            always_ff @(posedge clk_in)
            begin
                if (!rst_b_in)
                begin
                    pre_q <= 8'h00;
                end
                else if (clk_en_in)
                begin
                    if (!ctl[`BIT_RUN])
                    begin
                        pre_q <= 8'h00;
                    end
                    else if (active && src_tick)
                    begin
                        if (pre_q >= presc_limit(ctl[`BIT_PRESC_HI:`BIT_PRESC_LO]))
                        begin
                            pre_q <= 8'h00;
                        end
                        else
                        begin
                            pre_q <= pre_q + 8'h01;
                        end
                    end
                end
            end

            assign tick[gi] = clk_en_in & active & src_tick &
                              (pre_q >= presc_limit(ctl[`BIT_PRESC_HI:`BIT_PRESC_LO]));
            assign gate_fall[gi] = clk_en_in & active & gated & ~lvl_q & lvl_d1_q;
        end
    endgenerate

    // Period match of each 16-bit timer and of the joined pair.
    logic [NTMR-1:0] match16;
    logic            match32;
    logic [NTMR-1:0] set_flag;

    always_comb
    begin
        for (int i = 0; i < NTMR; i++)
        begin
            match16[i] = (cnt_q[i] == per_q[i]);
        end
    end

    assign match32 = ({cnt_q[TMR_UPPER], cnt_q[TMR_LOWER]} ==
                      {per_q[TMR_UPPER], per_q[TMR_LOWER]});

    always_comb
    begin
        set_flag[TMR_SINGLE] = (tick[TMR_SINGLE] & match16[TMR_SINGLE]) | gate_fall[TMR_SINGLE];
        if (pair_mode)
        begin
            set_flag[TMR_LOWER] = 1'b0;
            set_flag[TMR_UPPER] = (tick[TMR_LOWER] & match32) | gate_fall[TMR_LOWER];
        end
        else
        begin
            set_flag[TMR_LOWER] = (tick[TMR_LOWER] & match16[TMR_LOWER]) | gate_fall[TMR_LOWER];
            set_flag[TMR_UPPER] = (tick[TMR_UPPER] & match16[TMR_UPPER]) | gate_fall[TMR_UPPER];
        end
    end

    // Control and period registers.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            for (int i = 0; i < NTMR; i++)
            begin
                ctl_q[i] <= `CTL_RESET;
                per_q[i] <= `PER_RESET;
            end
            irq_cfg_q <= 12'h000;
        end
        else if (wr_ok)
        begin
            unique case (addr_in)
                `ADDR_SINGLE_CTL: ctl_q[TMR_SINGLE] <= wr_data_in & ctl_mask(0);
                `ADDR_LOWER_CTL:  ctl_q[TMR_LOWER]  <= wr_data_in & ctl_mask(1);
                `ADDR_UPPER_CTL:  ctl_q[TMR_UPPER]  <= wr_data_in & ctl_mask(2);
                `ADDR_SINGLE_PER: per_q[TMR_SINGLE] <= wr_data_in;
                `ADDR_LOWER_PER:  per_q[TMR_LOWER]  <= wr_data_in;
                `ADDR_UPPER_PER:  per_q[TMR_UPPER]  <= wr_data_in;
                `ADDR_IRQ_CFG:    irq_cfg_q <= wr_data_in[11:0];
                default:          ;
            endcase
        end
    end

    // Single timer count; a software write wins over an increment.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            cnt_q[TMR_SINGLE] <= `CNT_RESET;
        end
        else if (wr_ok && addr_in == `ADDR_SINGLE_CNT)
        begin
            cnt_q[TMR_SINGLE] <= wr_data_in;
        end
        else if (tick[TMR_SINGLE])
        begin
            cnt_q[TMR_SINGLE] <= match16[TMR_SINGLE] ? 16'h0000 : cnt_q[TMR_SINGLE] + 16'h0001;
        end
    end

    // Pair counts; joined mode carries the low word into the high word.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            cnt_q[TMR_LOWER] <= `CNT_RESET;
            cnt_q[TMR_UPPER] <= `CNT_RESET;
        end
        else
        begin
            if (wr_ok && addr_in == `ADDR_LOWER_CNT)
            begin
                cnt_q[TMR_LOWER] <= wr_data_in;
            end
            else if (tick[TMR_LOWER])
            begin
                if (pair_mode ? match32 : match16[TMR_LOWER])
                begin
                    cnt_q[TMR_LOWER] <= 16'h0000;
                end
                else
                begin
                    cnt_q[TMR_LOWER] <= cnt_q[TMR_LOWER] + 16'h0001;
                end
            end

            if (wr_ok && addr_in == `ADDR_UPPER_CNT)
            begin
                cnt_q[TMR_UPPER] <= wr_data_in;
            end
            else if (pair_mode)
            begin
                if (tick[TMR_LOWER])
                begin
                    if (match32)
                    begin
                        cnt_q[TMR_UPPER] <= 16'h0000;
                    end
                    else if (cnt_q[TMR_LOWER] == 16'hFFFF)
                    begin
                        cnt_q[TMR_UPPER] <= cnt_q[TMR_UPPER] + 16'h0001;
                    end
                end
            end
            else if (tick[TMR_UPPER])
            begin
                cnt_q[TMR_UPPER] <= match16[TMR_UPPER] ? 16'h0000 : cnt_q[TMR_UPPER] + 16'h0001;
            end
        end
    end

    // Flags: write one to clear, and a new event beats the clear.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            flag_q <= 3'b000;
        end
        else if (clk_en_in)
        begin
            for (int i = 0; i < NTMR; i++)
            begin
                if (set_flag[i])
                begin
                    flag_q[i] <= 1'b1;
                end
                else if (wr_ok && addr_in == `ADDR_IRQ_FLAGS && wr_data_in[i])
                begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    end

    // Requests follow flags gated by enables; the trigger is a one-cycle pulse.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            irq_req_q  <= 3'b000;
            adc_trig_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            irq_req_q  <= (flag_q | set_flag) & {irq_cfg_q[11], irq_cfg_q[7], irq_cfg_q[3]};
            adc_trig_q <= set_flag[TMR_UPPER];
        end
    end

    // Read port: data stands only in the cycle after the strobe.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            rd_data_q <= 16'h0000;
        end
        else if (rd_ok)
        begin
            unique case (addr_in)
                `ADDR_SINGLE_CTL: rd_data_q <= ctl_q[TMR_SINGLE];
                `ADDR_SINGLE_CNT: rd_data_q <= cnt_q[TMR_SINGLE];
                `ADDR_SINGLE_PER: rd_data_q <= per_q[TMR_SINGLE];
                `ADDR_LOWER_CTL:  rd_data_q <= ctl_q[TMR_LOWER];
                `ADDR_UPPER_CTL:  rd_data_q <= ctl_q[TMR_UPPER];
                `ADDR_LOWER_CNT:  rd_data_q <= cnt_q[TMR_LOWER];
                `ADDR_UPPER_CNT:  rd_data_q <= cnt_q[TMR_UPPER];
                `ADDR_LOWER_PER:  rd_data_q <= per_q[TMR_LOWER];
                `ADDR_UPPER_PER:  rd_data_q <= per_q[TMR_UPPER];
                `ADDR_IRQ_FLAGS:  rd_data_q <= {13'h0000, flag_q};
                `ADDR_IRQ_CFG:    rd_data_q <= {4'h0, irq_cfg_q};
                default:          rd_data_q <= 16'h0000;
            endcase
        end
        else if (clk_en_in)
        begin
            rd_data_q <= 16'h0000;
        end
    end

    assign rd_data_out                   = rd_data_q;
    assign irq_flag_out                  = flag_q;
    assign irq_req_out                   = irq_req_q;
    assign single_timer_irq_priority_out = irq_cfg_q[2:0];
    assign lower_irq_priority_out        = irq_cfg_q[10:8];
    assign pair_irq_priority_out         = irq_cfg_q[6:4];
    assign pair_count_low_out            = cnt_q[TMR_LOWER];
    assign pair_count_high_out           = cnt_q[TMR_UPPER];
    assign adc_trigger_out               = adc_trig_q;
endmodule

// *** tb/gp_timer_props.sv ***
// Port-level assertions for the timer block.
`timescale 1ns/1ps
`include "gp_timer_consts.svh"

module gp_timer_props
(
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic        clk_en_in,
    // Register port
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic        wr_stb_in,
    input wire logic        rd_stb_in,
    input wire logic [15:0] rd_data_out,
    // Status and time bases
    input wire logic [2:0]  irq_flag_out,
    input wire logic [2:0]  irq_req_out,
    input wire logic [15:0] pair_count_low_out,
    input wire logic [15:0] pair_count_high_out,
    input wire logic        adc_trigger_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_read_data_idle: assert property (
        !$past(rd_stb_in && clk_en_in) && $past(clk_en_in) |-> rd_data_out == 16'h0000)
        else $error("read data out of slot");
    a_unmapped_reads_zero: assert property (
        rd_stb_in && clk_en_in && addr_in > `ADDR_IRQ_CFG |=> rd_data_out == 16'h0000) else $error("unmapped read");
    a_adc_single_pulse: assert property (
        adc_trigger_out |=> !adc_trigger_out) else $error("trigger longer than one cycle");
    a_adc_with_flag: assert property (
        adc_trigger_out |-> irq_flag_out[2]) else $error("trigger without upper flag");
    a_low_count_step: assert property (
        !$past(wr_stb_in) && $changed(pair_count_low_out) |->
        pair_count_low_out == $past(pair_count_low_out) + 16'h0001 || pair_count_low_out == 16'h0000)
        else $error("low count jumped");
    a_high_count_step: assert property (
        !$past(wr_stb_in) && $changed(pair_count_high_out) |->
        pair_count_high_out == $past(pair_count_high_out) + 16'h0001 || pair_count_high_out == 16'h0000)
        else $error("high count jumped");
    a_flag_clear_write: assert property (
        $fell(irq_flag_out[0]) |-> $past(wr_stb_in && clk_en_in && addr_in == `ADDR_IRQ_FLAGS && wr_data_in[0]))
        else $error("flag fell without clear");
    a_req_has_flag: assert property (
        irq_req_out[0] |-> irq_flag_out[0] || $past(irq_flag_out[0])) else $error("request without flag");
    a_freeze_no_enable: assert property (
        !clk_en_in |=> $stable(pair_count_low_out) && $stable(irq_flag_out) && $stable(rd_data_out))
        else $error("state moved while frozen");

    c_adc_pulse: cover property (adc_trigger_out);
    c_flag_cleared: cover property ($fell(irq_flag_out[0]));
    c_frozen_write: cover property (!clk_en_in && wr_stb_in);
endmodule

bind gp_timer gp_timer_props gp_timer_props_inst
(
    .clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in), .rd_data_out(rd_data_out),
    .irq_flag_out(irq_flag_out), .irq_req_out(irq_req_out), .pair_count_low_out(pair_count_low_out),
    .pair_count_high_out(pair_count_high_out), .adc_trigger_out(adc_trigger_out)
);

// *** tb/pin_source.sv ***
// Model of the external clock and gate pin drivers.
`timescale 1ns/1ps

module pin_source
(
    // Clock
    input  wire logic       clk_in,
    // Pins: bit 0 single timer, bit 1 pair, bit 2 upper timer
    output logic      [2:0] pin_out = 3'b000
);
    // Pulses last several cycles so each one survives the synchroniser and its agreement stage.
    task automatic pulses(input int sel, input int n, input int w);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_in);
            pin_out[sel] <= 1'b1;
            repeat (w) @(posedge clk_in);
            pin_out[sel] <= 1'b0;
            repeat (w) @(posedge clk_in);
        end
    endtask
endmodule

// *** tb/gp_timer_bench.sv ***
// Self-checking bench for the timer block.
`timescale 1ns/1ps
`include "gp_timer_consts.svh"

module gp_timer_bench
    import gp_timer_pkg::*;
;
    logic        clk_in     = 1'b0;
    logic        rst_b_in   = 1'b0;
    logic        clk_en_in  = 1'b1;
    logic        idle_in    = 1'b0;
    logic [3:0]  addr_in    = 4'h0;
    word_t       wr_data_in = 16'h0000;
    logic        wr_stb_in  = 1'b0;
    logic        rd_stb_in  = 1'b0;
    word_t       rd_data_out;
    logic [2:0]  irq_flag_out;
    logic [2:0]  irq_req_out;
    logic [2:0]  prio_s, prio_l, prio_p;
    word_t       low_q, high_q;
    logic        adc_trigger_out;
    logic [2:0]  pin;
    word_t       rv, hold;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          cycles      = 0;
    int          adc_pulses  = 0;
    int          dv [4]      = '{1, 8, 64, 256};
    logic [3:0]  ra [11]     = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB};
    word_t       rval [11]   = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};
    logic [3:0]  ca [3]      = '{`ADDR_SINGLE_CTL, `ADDR_LOWER_CTL, `ADDR_UPPER_CTL};
    word_t       cm [3]      = '{`MASK_SINGLE_CTL, `MASK_LOWER_CTL, `MASK_UPPER_CTL};

    gp_timer gp_timer_inst
    (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in), .idle_in(idle_in),
        .single_timer_ext_clock_pin_in(pin[0]), .pair_ext_clock_pin_in(pin[1]), .upper_ext_clock_pin_in(pin[2]),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in),
        .rd_data_out(rd_data_out), .irq_flag_out(irq_flag_out), .irq_req_out(irq_req_out),
        .single_timer_irq_priority_out(prio_s), .lower_irq_priority_out(prio_l), .pair_irq_priority_out(prio_p),
        .pair_count_low_out(low_q), .pair_count_high_out(high_q), .adc_trigger_out(adc_trigger_out)
    );
    pin_source pin_source_inst (.clk_in(clk_in), .pin_out(pin));

    always #5 clk_in = ~clk_in;

    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (adc_trigger_out === 1'b1)
            adc_pulses <= adc_pulses + 1;
        if (cycles == 20000)
        begin
            $display("mismatch %0t timeout", $time);
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input word_t d);
        @(posedge clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_stb_in  <= 1'b1;
        @(posedge clk_in);
        wr_stb_in  <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        addr_in   <= a;
        rd_stb_in <= 1'b1;
        @(posedge clk_in);
        rd_stb_in <= 1'b0;
        #1 rv = rd_data_out;
    endtask

    task automatic chk(input word_t got, input word_t exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input word_t got, input int lo, input int hi);
        tests_run++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            miscompares++;
            $display("mismatch %0t got %0d want %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // Polls after each edge has settled; a miss shows up in the comparison that follows.
    task automatic wait_flag(input int b);
        for (int n = 0; n < 300 && irq_flag_out[b] !== 1'b1; n++)
            @(posedge clk_in) #1;
    endtask

    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_b_in  <= 1'b1;
        clk_en_in <= 1'b0;
        wr(`ADDR_SINGLE_PER, 16'h1234);
        clk_en_in <= 1'b1;
        foreach (ra[i])
        begin
            rd(ra[i]);
            chk(rv, rval[i]);
        end
        foreach (ca[i])
        begin
            wr(ca[i], 16'hFFFF);
            rd(ca[i]);
            chk(rv, cm[i]);
            wr(ca[i], 16'h0000);
        end
        wr(`ADDR_IRQ_CFG, 16'h0EDD);
        rd(`ADDR_IRQ_CFG);
        chk(rv, 16'h0EDD);
        chk({7'h00, prio_s, prio_p, prio_l}, 16'h016E);
        for (int p = 0; p < 4; p++)
        begin
            wr(`ADDR_SINGLE_CNT, 16'h0000);
            wr(`ADDR_SINGLE_CTL, 16'h8000 | word_t'(p << 4));
            repeat (1024) @(posedge clk_in);
            wr(`ADDR_SINGLE_CTL, 16'h0000);
            rd(`ADDR_SINGLE_CNT);
            chk_rng(rv, 1026 / dv[p] - 2, 1026 / dv[p] + 2);
            hold = rv;
            rd(`ADDR_SINGLE_CNT);
            chk(rv, hold);
        end
        wr(`ADDR_SINGLE_CNT, 16'h0000);
        wr(`ADDR_SINGLE_PER, 16'h0009);
        wr(`ADDR_IRQ_FLAGS, 16'h0007);
        wr(`ADDR_SINGLE_CTL, 16'h8000);
        wait_flag(0);
        rd(`ADDR_SINGLE_CNT);
        chk_rng(rv, 0, 3);
        chk({15'h0000, irq_req_out[0]}, 16'h0001);
        wr(`ADDR_SINGLE_CTL, 16'h0000);
        wr(`ADDR_IRQ_FLAGS, 16'h0001);
        rd(`ADDR_IRQ_FLAGS);
        chk(rv, 16'h0000);
        chk(word_t'(adc_pulses), 16'h0000);
        wr(`ADDR_SINGLE_PER, 16'hFFFF);
        idle_in <= 1'b1;
        wr(`ADDR_SINGLE_CNT, 16'h0000);
        wr(`ADDR_SINGLE_CTL, 16'hA000);
        repeat (20) @(posedge clk_in);
        rd(`ADDR_SINGLE_CNT);
        chk(rv, 16'h0000);
        wr(`ADDR_SINGLE_CTL, 16'h8000);
        repeat (20) @(posedge clk_in);
        rd(`ADDR_SINGLE_CNT);
        chk_rng(rv, 20, 26);
        wr(`ADDR_SINGLE_CTL, 16'h8046);
        idle_in <= 1'b0;
        wr(`ADDR_SINGLE_CNT, 16'h0000);
        pin_source_inst.pulses(0, 5, 6);
        rd(`ADDR_SINGLE_CNT);
        chk(rv, 16'h0005);
        wr(`ADDR_SINGLE_CTL, 16'h8002);
        pin_source_inst.pulses(0, 5, 6);
        rd(`ADDR_SINGLE_CNT);
        chk(rv, 16'h000A);
        wr(`ADDR_SINGLE_CNT, 16'h0000);
        wr(`ADDR_SINGLE_CTL, 16'h8040);
        repeat (30) @(posedge clk_in);
        rd(`ADDR_SINGLE_CNT);
        chk(rv, 16'h0000);
        pin_source_inst.pulses(0, 1, 40);
        rd(`ADDR_SINGLE_CNT);
        chk_rng(rv, 37, 43);
        chk({13'h0000, irq_flag_out}, 16'h0001);
        wr(`ADDR_SINGLE_CTL, 16'h0000);
        wr(`ADDR_IRQ_FLAGS, 16'h0007);
        wr(`ADDR_LOWER_CNT, 16'hFFF0);
        wr(`ADDR_LOWER_PER, 16'h0004);
        wr(`ADDR_UPPER_PER, 16'h0001);
        wr(`ADDR_UPPER_CTL, 16'hA030);
        idle_in <= 1'b1;
        wr(`ADDR_LOWER_CTL, 16'h8008);
        for (int n = 0; n < 40 && high_q !== 16'h0001; n++)
            @(posedge clk_in) #1;
        chk(high_q, 16'h0001);
        chk(low_q, 16'h0000);
        wait_flag(2);
        chk({low_q, high_q} == 32'h0000_0000 ? 16'h0000 : 16'h0001, 16'h0000);
        chk({13'h0000, irq_flag_out}, 16'h0004);
        repeat (3) @(posedge clk_in);
        chk(word_t'(adc_pulses), 16'h0001);
        wr(`ADDR_LOWER_CTL, 16'h0008);
        #1 hold = low_q;
        repeat (10) @(posedge clk_in);
        chk(low_q, hold);
        idle_in <= 1'b0;
        wr(`ADDR_UPPER_CTL, 16'h0000);
        wr(`ADDR_UPPER_CNT, 16'h0000);
        wr(`ADDR_LOWER_CNT, 16'h0000);
        wr(`ADDR_IRQ_FLAGS, 16'h0007);
        wr(`ADDR_LOWER_CTL, 16'h8000);
        wait_flag(1);
        chk({13'h0000, irq_flag_out}, 16'h0002);
        chk(high_q, 16'h0000);
        end_sim();
    end
endmodule
